/* File: hdl/ppm_top.sv */
// Port pin function multiplexer: ports 0, 2 and 5, IR transmit pin, JTAG pins.
// Assumes pins are resolved outside from dout/oe/pu; TAP state comes from the TAP.
// Summary of operation
// - Infrared transmit pin is active low; low level means transmitting.
// - During any reset, IR transmit pin is three-state input without pullup.
// - All plain port pins come up three-state after reset, no function active.
// - Lower four pins of second serial port come up three-state after reset.
// - Alternate functions other than JTAG stay off until software enables them.
// - Enabled special function disconnects the pin's general-purpose control.
// - After reset the four debug pins are JTAG with weak pullups on.
// - Clearing the debug enable bit returns the debug pins to general use.
// - TDO rests as pulled-up input; drives only in Shift-IR or Shift-DR.
`include "ppm_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ppm_top
#(
  parameter int W = `PPM_PORT_W
)
(
  input  wire logic                mclk,            // System clock 10 MHz
  input  wire logic                rstn,            // Sync reset, any source
  input  wire logic                ce,              // Clock enable
  input  wire logic [2:0][W-1:0]   sel_wr,          // Select write strobes, ports 0/2/5
  input  wire logic [2:0][W-1:0]   sel_val,         // Select write values
  input  var  ppm_pkg::ppm_drive_t gpio_drv [3],    // GPIO drive per port
  input  var  ppm_pkg::ppm_drive_t periph_drv [3],  // Peripheral drive per port
  input  wire logic                dbg_enable_wr,   // System control debug bit write
  input  wire logic                dbg_enable_val,  // System control debug bit value
  input  wire logic                tap_shift,       // TAP in Shift-IR or Shift-DR
  input  wire logic                tap_tdo,         // TAP test-data out
  input  wire logic                ir_cfg_wr,       // IR pin configure strobe
  input  wire logic                ir_tx_active,    // IR transmit asserted
  input  wire logic                ir_pullup_en,    // IR pullup wanted after config
  input  wire logic [W-1:0]        p2_pin_in,       // Second serial port pin levels
  output ppm_pkg::ppm_pins_t       port0,           // First port drive
  output ppm_pkg::ppm_pins_t       port2,           // Second serial port drive
  output ppm_pkg::ppm_pins_t       port5,           // Fifth port drive
  output logic                     ir_tx_out,       // IR transmit level
  output logic                     ir_tx_oe,        // IR transmit enable
  output logic                     ir_tx_pu,        // IR weak pullup
  output logic                     dbg_enable,      // Debug port enabled
  output logic [3:0]               jtag_in          // Synced TCK,TDI,TMS,TDO
);
  typedef struct packed {
    logic                dbg_en;
    logic                ir_cfg;
    logic                ir_out;
    logic                ir_oe;
    logic                ir_pu;
    ppm_pkg::ppm_pins_t  p2;
    ppm_pkg::ppm_sync_t  sync;
  } ppm_state_t;
  ppm_state_t s;
  ppm_state_t next_s;

  ppm_pkg::ppm_drive_t mux_pin [3];
  logic [W-1:0]        mux_sel [3];

  for (genvar g = 0; g < 3; g++)
  begin : g_port
    ppm_port_mux #(.W(W)) u_mux
    (
      .mclk    (mclk),
      .rstn    (rstn),
      .ce      (ce),
      .sel_wr  (sel_wr[g]),
      .sel_val (sel_val[g]),
      .gpio    (gpio_drv[g]),
      .periph  (periph_drv[g]),
      .pin     (mux_pin[g]),
      .sel     (mux_sel[g])
    );
  end

  always_comb
  begin
    next_s = s;
    if (dbg_enable_wr)
      next_s.dbg_en = dbg_enable_val;
    if (ir_cfg_wr)
      next_s.ir_cfg = 1'b1;
    // IR pin is three-state until software configures it
    next_s.ir_out = !ir_tx_active;
    next_s.ir_oe  = next_s.ir_cfg;
    next_s.ir_pu  = next_s.ir_cfg && ir_pullup_en;
    // Three-stage sampler; a change counts when stages two and three agree
    next_s.sync.q1 = p2_pin_in;
    next_s.sync.q2 = s.sync.q1;
    next_s.sync.q3 = s.sync.q2;
    for (int i = 0; i < W; i++)
    begin
      if (s.sync.q2[i] == s.sync.q3[i])
        next_s.sync.val[i] = s.sync.q3[i];
    end
    next_s.p2.dout = mux_pin[1].dout;
    next_s.p2.oe   = mux_pin[1].oe;
    next_s.p2.pu   = `PPM_ZERO8;
    if (next_s.dbg_en)
    begin
      // Debug pins: inputs with pullups, TDO drives only while shifting
      next_s.p2.oe[`PPM_DBG_TCK] = 1'b0;
      next_s.p2.oe[`PPM_DBG_TDI] = 1'b0;
      next_s.p2.oe[`PPM_DBG_TMS] = 1'b0;
      next_s.p2.pu[`PPM_DBG_TDO:`PPM_DBG_TCK] = `PPM_ONES4;
      next_s.p2.oe[`PPM_DBG_TDO]   = tap_shift;
      next_s.p2.dout[`PPM_DBG_TDO] = tap_tdo;
    end
    if (!rstn)
    begin
      next_s.dbg_en = 1'b1;
      next_s.ir_cfg = 1'b0;
      next_s.ir_out = 1'b1;
      next_s.ir_oe  = 1'b0;
      next_s.ir_pu  = 1'b0;
      next_s.p2.dout = `PPM_ZERO8;
      next_s.p2.oe   = `PPM_ZERO8;
      next_s.p2.pu   = {`PPM_ONES4, 4'h0};
      next_s.sync    = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (ce || !rstn)
      s <= next_s;
  end

  // Ports 0 and 5 come straight from the mux flip-flops
  assign port0.dout = mux_pin[0].dout;
  assign port0.oe   = mux_pin[0].oe;
  assign port0.pu   = `PPM_ZERO8;
  assign port5.dout = mux_pin[2].dout;
  assign port5.oe   = mux_pin[2].oe;
  assign port5.pu   = `PPM_ZERO8;
  assign port2      = s.p2;
  assign ir_tx_out  = s.ir_out;
  assign ir_tx_oe   = s.ir_oe;
  assign ir_tx_pu   = s.ir_pu;
  assign dbg_enable = s.dbg_en;
  assign jtag_in    = s.sync.val[`PPM_DBG_TDO:`PPM_DBG_TCK];

  // Reset values show at the edge after rstn is sampled low
  a_ir_reset : assert property (@(posedge mclk)
    !rstn |=> !ir_tx_oe && !ir_tx_pu && ir_tx_out)
    else $error("IR pin not three-state after reset");

  a_p2_low_tri : assert property (@(posedge mclk)
    !rstn |=> port2.oe[`PPM_SER2_LO_W-1:0] == '0)
    else $error("Low serial pins not three-state after reset");

  a_port_tri : assert property (@(posedge mclk)
    !rstn |=> port0.oe == '0 && port5.oe == '0 && port0.pu == '0 && port5.pu == '0)
    else $error("Port driver active after reset");

  a_dbg_pullup : assert property (@(posedge mclk)
    !rstn |=> dbg_enable && port2.pu[`PPM_DBG_TDO:`PPM_DBG_TCK] == `PPM_ONES4)
    else $error("Debug pins lack JTAG pullups after reset");

  // IR pin: active-low data, driven only once configured
  a_ir_polarity : assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $past(ce) && ir_tx_oe |-> ir_tx_out == !$past(ir_tx_active))
    else $error("IR output polarity wrong");

  a_ir_unconfig : assert property (@(posedge mclk) disable iff (!rstn)
    !s.ir_cfg |-> !ir_tx_oe)
    else $error("IR pin driven before configuration");

  a_ir_config : assert property (@(posedge mclk) disable iff (!rstn)
    ce && ir_cfg_wr |=> ir_tx_oe)
    else $error("IR pin not driven after configuration");

  // Debug pins
  a_dbg_clear : assert property (@(posedge mclk) disable iff (!rstn)
    ce && dbg_enable_wr && !dbg_enable_val |=> !dbg_enable && port2.pu[7:4] == 4'h0)
    else $error("Debug pins not released");

  a_p2_release : assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $past(ce) && !dbg_enable |-> port2.oe == $past(mux_pin[1].oe) && port2.pu == '0)
    else $error("Released debug pins not under general control");

  a_tdo_gate : assert property (@(posedge mclk) disable iff (!rstn)
    dbg_enable && port2.oe[7] |-> $past(tap_shift))
    else $error("TDO driven outside shift state");

  a_tdo_rest : assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $past(ce) && dbg_enable && !$past(tap_shift)
    |-> !port2.oe[`PPM_DBG_TDO] && port2.pu[`PPM_DBG_TDO])
    else $error("TDO not resting as pulled-up input");

  a_dbg_sel : assert property (@(posedge mclk) disable iff (!rstn)
    dbg_enable |-> port2.oe[6:4] == 3'h0)
    else $error("Debug input pin driven");

  a_jtag_sample : assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $past(ce)
    && $past(s.sync.q2[`PPM_DBG_TDO:`PPM_DBG_TCK]) == $past(s.sync.q3[`PPM_DBG_TDO:`PPM_DBG_TCK])
    |-> jtag_in == $past(s.sync.q3[`PPM_DBG_TDO:`PPM_DBG_TCK]))
    else $error("Debug pin sample taken before stages agree");

  // Select routing and clock-enable hold
  a_p0_route : assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $past(ce)
    |-> port0.oe == ((mux_sel[0] & $past(periph_drv[0].oe)) | (~mux_sel[0] & $past(gpio_drv[0].oe))))
    else $error("Port zero enable not routed by select");

  a_p5_route : assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && $past(ce)
    |-> port5.dout == ((mux_sel[2] & $past(periph_drv[2].dout)) | (~mux_sel[2] & $past(gpio_drv[2].dout))))
    else $error("Port five data not routed by select");

  a_ce_hold : assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) && !$past(ce)
    |-> $stable(mux_sel[0]) && $stable(mux_sel[1]) && $stable(mux_sel[2]) && $stable(port2))
    else $error("State moved while clock enable low");

  // Main scenarios
  c_ir_cfg    : cover property (@(posedge mclk) disable iff (!rstn) $rose(ir_tx_oe));
  c_tdo_shift : cover property (@(posedge mclk) disable iff (!rstn) dbg_enable && port2.oe[7]);
  c_dbg_off   : cover property (@(posedge mclk) disable iff (!rstn) $fell(dbg_enable));
  c_periph    : cover property (@(posedge mclk) disable iff (!rstn) mux_sel[0] != '0);
  c_p2_periph : cover property (@(posedge mclk) disable iff (!rstn) !dbg_enable && mux_sel[1] != '0);
endmodule
`default_nettype wire

/* File: hdl/ppm_defs.svh */
// Constants for the port pin function multiplexer.
// Assumes inclusion by bare name from hdl/ files.
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH
`define PPM_PORT_W     8
`define PPM_SER2_LO_W  4
`define PPM_DBG_TCK    4
`define PPM_DBG_TDI    5
`define PPM_DBG_TMS    6
`define PPM_DBG_TDO    7
`define PPM_SEL_RST    8'h00
`define PPM_ZERO8      8'h00
`define PPM_ONES4      4'hf
`endif

/* File: hdl/ppm_pkg.sv */
// Types for the port pin function multiplexer.
// Assumes ppm_defs.svh is on the include path.
`include "ppm_defs.svh"
package ppm_pkg;
  typedef struct packed {
    logic [`PPM_PORT_W-1:0] dout;
    logic [`PPM_PORT_W-1:0] oe;
    logic [`PPM_PORT_W-1:0] pu;
  } ppm_pins_t;
  typedef struct packed {
    logic [`PPM_PORT_W-1:0] dout;
    logic [`PPM_PORT_W-1:0] oe;
  } ppm_drive_t;
  typedef struct packed {
    logic [`PPM_PORT_W-1:0] q1;
    logic [`PPM_PORT_W-1:0] q2;
    logic [`PPM_PORT_W-1:0] q3;
    logic [`PPM_PORT_W-1:0] val;
  } ppm_sync_t;
endpackage

/* File: hdl/ppm_port_mux.sv */
// One port of pins: per-pin function select, resets to general purpose.
// Assumes ppm_pkg compiled before; single clock mclk, sync reset rstn.
`include "ppm_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ppm_port_mux
#(
  parameter int W = `PPM_PORT_W
)
(
  input  wire logic                      mclk,     // System clock
  input  wire logic                      rstn,     // Sync reset, low
  input  wire logic                      ce,       // Clock enable
  input  wire logic [W-1:0]              sel_wr,   // Select write strobe per pin
  input  wire logic [W-1:0]              sel_val,  // Select value to write
  input  var  ppm_pkg::ppm_drive_t       gpio,     // General-purpose drive
  input  var  ppm_pkg::ppm_drive_t       periph,   // Peripheral drive
  output var  ppm_pkg::ppm_drive_t       pin,      // Registered pin drive
  output logic [W-1:0]                   sel       // Current selects
);
  typedef struct packed {
    logic [W-1:0]        sel;
    ppm_pkg::ppm_drive_t pin;
  } ppm_pm_state_t;
  ppm_pm_state_t s;
  ppm_pm_state_t next_s;

  always_comb
  begin
    next_s = s;
    for (int i = 0; i < W; i++)
    begin
      if (sel_wr[i])
        next_s.sel[i] = sel_val[i];
    end
    // Selected peripheral alone owns the pin
    for (int i = 0; i < W; i++)
    begin
      next_s.pin.dout[i] = next_s.sel[i] ? periph.dout[i] : gpio.dout[i];
      next_s.pin.oe[i]   = next_s.sel[i] ? periph.oe[i] : gpio.oe[i];
    end
    if (!rstn)
    begin
      next_s.sel      = `PPM_SEL_RST;
      next_s.pin.dout = `PPM_ZERO8;
      next_s.pin.oe   = `PPM_ZERO8;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (ce || !rstn)
      s <= next_s;
  end

  assign pin = s.pin;
  assign sel = s.sel;

  a_mux_owner : assert property (@(posedge mclk) disable iff (!rstn)
    ce && $past(ce) && $past(rstn) && s.sel[0] |-> s.pin.oe[0] == $past(periph.oe[0]))
    else $error("Selected pin not owned by peripheral");
  a_sel_reset : assert property (@(posedge mclk)
    !rstn |=> s.sel == '0 && s.pin.oe == '0)
    else $error("Select or driver not cleared by reset");
endmodule
`default_nettype wire

/* File: tb/ppm_board.sv */
// Board model: pad resolution of the second serial port plus a JTAG debugger.
// Assumes ppm_pkg compiled first; floating pads toggle each clock.
`timescale 1ns/10ps
`default_nettype none
module ppm_board
(
  input  wire logic          clk,      // Board clock for floating pattern
  input  var  ppm_pkg::ppm_pins_t port2, // Device drive of the port
  input  wire logic          dbg_act,  // Debugger attached
  input  wire logic [2:0]    dbg_lvl,  // Debugger TCK,TDI,TMS levels
  output logic      [7:0]    pin       // Resolved pad levels
);
  logic [7:0] flt = 8'h00;
  always @(posedge clk) flt <= ~flt;
  always_comb
    for (int i = 0; i < 8; i++)
      if (port2.oe[i])
        pin[i] = port2.dout[i];
      else if (dbg_act && i >= 4 && i <= 6)
        pin[i] = dbg_lvl[i-4];
      else
        pin[i] = port2.pu[i] ? 1'b1 : flt[i];
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for ppm_top with random drives and selects.
// Assumes hdl/ files and tb/ppm_board.sv compiled before.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1;
  logic [2:0][7:0] sel_wr = '0, sel_val = '0;
  ppm_pkg::ppm_drive_t gpio_drv [3] = '{default: '0};
  ppm_pkg::ppm_drive_t periph_drv [3] = '{default: '0};
  logic dbg_wr = 0, dbg_val = 0, tap_shift = 0, tap_tdo = 0;
  logic ir_wr = 0, ir_act = 0, ir_pu = 0, dbg_act = 0;
  logic [2:0] dbg_lvl = '0;
  logic [7:0] p2_in;
  logic [7:0] sel_m [3] = '{default: '0};
  logic dbg_m = 1, ir_m = 0, ir_out, ir_oe, ir_pu_o, dbg_en;
  logic [3:0] jtag_in;
  ppm_pkg::ppm_pins_t port0, port2, port5;
  int fails = 0, checked = 0, cycles = 0;
  ppm_top i_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .sel_wr(sel_wr), .sel_val(sel_val),
    .gpio_drv(gpio_drv), .periph_drv(periph_drv), .dbg_enable_wr(dbg_wr),
    .dbg_enable_val(dbg_val), .tap_shift(tap_shift), .tap_tdo(tap_tdo), .ir_cfg_wr(ir_wr),
    .ir_tx_active(ir_act), .ir_pullup_en(ir_pu), .p2_pin_in(p2_in), .port0(port0),
    .port2(port2), .port5(port5), .ir_tx_out(ir_out), .ir_tx_oe(ir_oe), .ir_tx_pu(ir_pu_o),
    .dbg_enable(dbg_en), .jtag_in(jtag_in));
  ppm_board i_board (.clk(mclk), .port2(port2), .dbg_act(dbg_act), .dbg_lvl(dbg_lvl), .pin(p2_in));
  always #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      conclude();
    end
  end
  task conclude;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic ppm_pkg::ppm_drive_t mux(logic [7:0] s, ppm_pkg::ppm_drive_t g, p);
    return '{dout: (s & p.dout) | (~s & g.dout), oe: (s & p.oe) | (~s & g.oe)};
  endfunction
  task settle;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask
  task chk_rst;
    chk("p05 oe", 8'h00, port0.oe | port5.oe);
    chk("p2 oe", 8'h00, port2.oe);
    chk("p2 pu", 8'hf0, port2.pu);
    chk("ir dbg", 8'h05, {5'h00, ir_out, ir_pu_o | ir_oe, dbg_en});
    chk("p05 pu", 8'h00, port0.pu | port5.pu);
  endtask
  task chk_all;
    ppm_pkg::ppm_drive_t e;
    logic [7:0] m;
    e = mux(sel_m[0], gpio_drv[0], periph_drv[0]);
    chk("p0 dout", e.dout, port0.dout);
    chk("p05 pu", 8'h00, port0.pu | port5.pu);
    chk("p0 oe", e.oe, port0.oe);
    e = mux(sel_m[2], gpio_drv[2], periph_drv[2]);
    chk("p5 oe", e.oe, port5.oe);
    chk("p5 dout", e.dout, port5.dout);
    e = mux(sel_m[1], gpio_drv[1], periph_drv[1]);
    m = dbg_m ? {tap_shift, 7'h0f} : 8'hff;
    if (dbg_m)
      {e.oe[7:4], e.dout[7]} = {tap_shift, 3'b000, tap_tdo};
    chk("p2 oe", e.oe, port2.oe);
    chk("p2 dout", e.dout & m, port2.dout & m);
    chk("p2 pu", dbg_m ? 8'hf0 : 8'h00, port2.pu);
    chk("ir", 8'({ir_m, ir_m & ir_pu, ir_m & ~ir_act, dbg_m}),
      8'({ir_oe, ir_pu_o, ir_m & ir_out, dbg_en}));
  endtask
  task rnd;
    int k;
    logic [7:0] w, v;
    @(posedge mclk);
    k = $urandom_range(2);
    w = 8'($urandom);
    v = 8'($urandom);
    for (int i = 0; i < 3; i++)
    begin
      gpio_drv[i] <= 16'($urandom);
      periph_drv[i] <= 16'($urandom);
    end
    {tap_shift, tap_tdo, ir_act, ir_pu} <= 4'($urandom);
    {sel_wr[k], sel_val[k]} <= {w, v};
    sel_m[k] = (sel_m[k] & ~w) | (w & v);
    @(posedge mclk);
    sel_wr <= '0;
    settle();
    chk_all();
  endtask
  task dbg_set(input logic v);
    @(posedge mclk);
    {dbg_wr, dbg_val} <= {1'b1, v};
    @(posedge mclk);
    dbg_wr <= 1'b0;
    dbg_m = v;
    settle();
    chk_all();
  endtask
  initial
  begin
    void'($urandom(60));
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    chk_rst();
    @(posedge mclk);
    rstn <= 1'b1;
    settle();
    chk_all();
    repeat (25) rnd();
    @(posedge mclk);
    {dbg_act, dbg_lvl} <= {1'b1, 3'($urandom)};
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk("jtag", {4'h0, tap_shift ? tap_tdo : 1'b1, dbg_lvl}, {4'h0, jtag_in});
    @(posedge mclk);
    ir_wr <= 1'b1;
    ir_pu <= 1'b1;
    @(posedge mclk);
    ir_wr <= 1'b0;
    ir_m = 1'b1;
    dbg_set(1'b0);
    repeat (25) rnd();
    @(posedge mclk);
    ce <= 1'b0;
    {sel_wr[0], sel_val[0]} <= {8'hff, ~sel_m[0]};
    @(posedge mclk);
    sel_wr <= '0;
    ce <= 1'b1;
    settle();
    chk_all();
    dbg_set(1'b1);
    repeat (10) rnd();
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk_rst();
    @(posedge mclk);
    rstn <= 1'b1;
    {sel_m[0], sel_m[1], sel_m[2], ir_m} = '0;
    settle();
    chk_all();
    conclude();
  end
endmodule
`default_nettype wire
